/* File: verilog/pic_pkg.sv */
// Package: register map, control field positions and sizes for the interval counter
package pic_pkg;
    // Byte addresses of the three registers
    localparam logic [7:0] PIC_ADDR_CTRL   = 8'h42;
    localparam logic [7:0] PIC_ADDR_RELOAD = 8'h43;
    localparam logic [7:0] PIC_ADDR_COUNT  = 8'h44;
    // Control field positions
    localparam int PIC_BIT_RX_LATCH   = 0;
    localparam int PIC_BIT_TX_VALUE   = 1;
    localparam int PIC_BIT_EDGE_ARM   = 2;
    localparam int PIC_BIT_COUNT_EN   = 3;
    localparam int PIC_BIT_TX_DRIVE   = 4;
    localparam int PIC_BIT_IRQ_SOURCE = 5;
    localparam int PIC_BIT_CLK_LOW    = 6;
    localparam int PIC_BIT_CLK_HIGH   = 7;
    // Reset values
    localparam logic [7:0] PIC_CTRL_RESET = 8'h00;
    localparam logic       PIC_RX_RESET   = 1'b1;
    localparam logic       PIC_TX_RESET   = 1'b1;
    // Carry event buffer shape
    localparam int PIC_FIFO_WIDTH = 8;
    localparam int PIC_FIFO_DEPTH = 8;
    // Clock source codes, {high, low}
    typedef enum logic [1:0] {
        PIC_SRC_PIN     = 2'h0,
        PIC_SRC_AUX     = 2'h1,
        PIC_SRC_MAIN    = 2'h2,
        PIC_SRC_PIN_AND = 2'h3
    } pic_src_t;
endpackage

/* File: verilog/pic_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module pic_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    wr_d;
    logic [AW-1:0]    rd_q;
    logic [AW-1:0]    rd_d;
    logic [AW:0]      fill_q;
    logic [AW:0]      fill_d;
    logic             push;
    logic             pop;

    assign in_ready  = (fill_q != (AW+1)'(DEPTH));
    assign out_valid = (fill_q != '0);
    assign out_data  = mem[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and fill level update
    always_comb
    begin
        wr_d   = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d   = pop ? AW'(rd_q + 1'b1) : rd_q;
        fill_d = fill_q;
        if (push && !pop)
        begin
            fill_d = fill_q + 1'b1;
        end
        else if (pop && !push)
        begin
            fill_d = fill_q - 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            wr_q   <= '0;
            rd_q   <= '0;
            fill_q <= '0;
        end
        else
        begin
            wr_q   <= wr_d;
            rd_q   <= rd_d;
            fill_q <= fill_d;
        end
    end

    // Storage has no reset; only valid entries are ever read
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_q] <= in_data;
        end
    end
endmodule

/* File: verilog/pic_counter.sv */
// Preloadable 8-bit interval counter with start-edge detect and serial bit latches
// How it works
// RL1 - Count up each selected clock edge when enabled; a full carry buffer stalls the count
// RL2 - Carry or counter write loads the preload value
// RL3 - Counter writes drop data; reads give live count
// RL4 - Preload register readable, writable, rewritable after load
// RL5 - Bits 7:6 choose pin, aux, main, pin-and-main
// RL6 - Bit 0 holds receive pin sampled at carry
// RL7 - Transmit bit reaches pin at next carry
// RL8 - Edge arm low holds edge flop cleared
// RL9 - Armed chosen edge sets flop until disarmed
// RL10 - Enable bit starts counting alongside edge flop
// RL11 - Drive bit forces output, else direction decides
// RL12 - Bit 5 routes pin or carry to flag
// RL13 - Flag clears on service; enable, edge unchanged
// RL14 - Software uses byte accesses, control at 042h
// RL15 - Full scale latches bits, reloads, keeps counting, interrupts
// RL16 - Falling start edge starts counting without processor
// RL17 - Carry is one-cycle pulse doing the reload
// RL18 - Reset clears control bits; data registers unchanged
`timescale 1ns/1ns
module pic_counter
    import pic_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    input  wire logic [7:0] ADDR,
    input  wire logic       WR_EN,
    input  wire logic       RD_EN,
    input  wire logic [7:0] WR_DATA,
    output logic      [7:0] RD_DATA,
    input  wire logic       AUX_CLK,
    input  wire logic       RECEIVE_PIN,
    input  wire logic       RECEIVE_PIN_EDGE_SELECT,
    input  wire logic       TRANSMIT_PIN_DIRECTION,
    output logic            TRANSMIT_PIN_OUT,
    output logic            TRANSMIT_PIN_OE_N,
    input  wire logic       IRQ_ACK,
    output logic            SHARED_PIN_IRQ_FLAG,
    output logic            CARRY_VALID,
    input  wire logic       CARRY_READY,
    output logic      [7:0] CARRY_DATA
);
    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers: three stages, change taken when stages two and three agree

    logic [2:0] rx_sync_q;
    logic [2:0] aux_sync_q;
    logic       rx_q;
    logic       rx_d;
    logic       aux_q;
    logic       aux_d;
    logic       rx_prev_q;
    logic       aux_prev_q;

    always_comb
    begin
        rx_d  = (rx_sync_q[1] == rx_sync_q[2]) ? rx_sync_q[2] : rx_q;
        aux_d = (aux_sync_q[1] == aux_sync_q[2]) ? aux_sync_q[2] : aux_q;
    end

    // Filtered levels plus one delayed copy for edge detection
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            rx_sync_q  <= 3'h7;
            aux_sync_q <= 3'h0;
            rx_q       <= 1'b1;
            aux_q      <= 1'b0;
            rx_prev_q  <= 1'b1;
            aux_prev_q <= 1'b0;
        end
        else
        begin
            rx_sync_q  <= {rx_sync_q[1:0], RECEIVE_PIN};
            aux_sync_q <= {aux_sync_q[1:0], AUX_CLK};
            rx_q       <= rx_d;
            aux_q      <= aux_d;
            rx_prev_q  <= rx_q;
            aux_prev_q <= aux_q;
        end
    end

    logic rx_rise;
    logic rx_fall;
    logic rx_sel_edge;
    logic aux_rise;

    // Pin edge select: 0 rising, 1 falling (falling catches a start bit)
    assign rx_rise     = rx_q && !rx_prev_q;
    assign rx_fall     = !rx_q && rx_prev_q;
    assign rx_sel_edge = RECEIVE_PIN_EDGE_SELECT ? rx_fall : rx_rise;
    assign aux_rise    = aux_q && !aux_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // Control register, counter, preload, latches and edge flop

    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [7:0] reload_q;
    logic [7:0] reload_d;
    logic       rx_latch_q;
    logic       rx_latch_d;
    logic       tx_latch_q;
    logic       tx_latch_d;
    logic       edge_ff_q;
    logic       edge_ff_d;
    logic       flag_q;
    logic       flag_d;
    logic       carry_q;
    logic       carry_d;
    logic       tick;
    logic       count_en;
    logic       wr_ctrl;
    logic       wr_reload;
    logic       wr_count;
    logic       irq_event;
    logic       fifo_in_ready;
    pic_src_t   src;

    assign wr_ctrl   = WR_EN && (ADDR == PIC_ADDR_CTRL);
    assign wr_reload = WR_EN && (ADDR == PIC_ADDR_RELOAD);
    assign wr_count  = WR_EN && (ADDR == PIC_ADDR_COUNT);
    assign src       = pic_src_t'({ctrl_q[PIC_BIT_CLK_HIGH], ctrl_q[PIC_BIT_CLK_LOW]});

    // Clock source pick; main clock ticks every cycle
    always_comb
    begin
        unique case (src) // RL5
            PIC_SRC_PIN:     tick = rx_sel_edge;
            PIC_SRC_AUX:     tick = aux_rise;
            PIC_SRC_MAIN:    tick = 1'b1;
            PIC_SRC_PIN_AND: tick = RECEIVE_PIN_EDGE_SELECT ? !rx_q : rx_q;
        endcase
    end

    // Enable bit or set edge flop starts counting
    assign count_en = ctrl_q[PIC_BIT_COUNT_EN] || edge_ff_q; // RL10 RL16

    // Full buffer stalls counting; with reload FFh and a tick every cycle, a back-to-back carry can still be dropped
    always_comb
    begin
        ctrl_d     = ctrl_q;
        count_d    = count_q;
        reload_d   = reload_q;
        rx_latch_d = rx_latch_q;
        tx_latch_d = tx_latch_q;
        edge_ff_d  = edge_ff_q;
        carry_d    = 1'b0;
        if (wr_ctrl)
        begin
            // Bit 0 is read only
            ctrl_d = {WR_DATA[7:1], 1'b0};
        end
        if (wr_reload)
        begin
            reload_d = WR_DATA; // RL4
        end
        if (!ctrl_q[PIC_BIT_EDGE_ARM])
        begin
            edge_ff_d = 1'b0; // RL8
        end
        else if (rx_sel_edge)
        begin
            edge_ff_d = 1'b1; // RL9
        end
        if (count_en && tick && fifo_in_ready)
        begin
            if (count_q == 8'hFF)
            begin
                // Rollover: reload and latch the serial bits in one step
                carry_d    = 1'b1; // RL17
                count_d    = reload_q; // RL2 RL15
                rx_latch_d = rx_q; // RL6
                tx_latch_d = ctrl_q[PIC_BIT_TX_VALUE]; // RL7
            end
            else
            begin
                count_d = count_q + 8'h01; // RL1
            end
        end
        if (wr_count)
        begin
            count_d = reload_q; // RL3
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            ctrl_q     <= PIC_CTRL_RESET; // RL18
            rx_latch_q <= PIC_RX_RESET;
            tx_latch_q <= PIC_TX_RESET;
            edge_ff_q  <= 1'b0;
            carry_q    <= 1'b0;
        end
        else
        begin
            ctrl_q     <= ctrl_d;
            rx_latch_q <= rx_latch_d;
            tx_latch_q <= tx_latch_d;
            edge_ff_q  <= edge_ff_d;
            carry_q    <= carry_d;
        end
    end

    // Data registers keep their contents through reset
    always_ff @(posedge CLK)
    begin
        count_q  <= count_d; // RL18
        reload_q <= reload_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared interrupt flag: set beats the service clear

    assign irq_event = ctrl_q[PIC_BIT_IRQ_SOURCE] ? carry_q : rx_sel_edge; // RL12

    always_comb
    begin
        flag_d = flag_q;
        if (IRQ_ACK)
        begin
            flag_d = 1'b0; // RL13
        end
        if (irq_event)
        begin
            flag_d = 1'b1; // RL15
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            flag_q <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all registered

    logic [7:0] rd_d;
    logic [7:0] rd_q;
    logic       tx_oe_n_d;
    logic       tx_oe_n_q;
    logic       tx_out_q;
    logic       flag_out_q;

    // Byte-wide read mux; unmapped addresses read zero
    always_comb
    begin
        rd_d = 8'h00;
        if (RD_EN)
        begin
            unique case (ADDR) // RL14
                PIC_ADDR_CTRL:   rd_d = {ctrl_q[7:1], rx_latch_q}; // RL6
                PIC_ADDR_RELOAD: rd_d = reload_q;
                PIC_ADDR_COUNT:  rd_d = count_q; // RL3
                default:         rd_d = 8'h00;
            endcase
        end
        // Low enable means driving
        tx_oe_n_d = !(ctrl_q[PIC_BIT_TX_DRIVE] || TRANSMIT_PIN_DIRECTION); // RL11
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            rd_q       <= 8'h00;
            tx_oe_n_q  <= 1'b1;
            tx_out_q   <= PIC_TX_RESET;
            flag_out_q <= 1'b0;
        end
        else
        begin
            rd_q       <= rd_d;
            tx_oe_n_q  <= tx_oe_n_d;
            tx_out_q   <= tx_latch_q;
            flag_out_q <= flag_q;
        end
    end

    assign RD_DATA             = rd_q;
    assign TRANSMIT_PIN_OE_N   = tx_oe_n_q;
    assign TRANSMIT_PIN_OUT    = tx_out_q;
    assign SHARED_PIN_IRQ_FLAG = flag_out_q;

    ////////////////////////////////////////////////////////////////////////////
    // Carry event buffer: each carry that finds room pushes the received bit with the low seven bits of the reload value

    logic [7:0] fifo_data;
    logic [7:0] fifo_data_out;
    logic       fifo_valid;
    logic [7:0] carry_data_q;
    logic       carry_valid_q;

    assign fifo_data = {rx_latch_q, reload_q[6:0]};

    pic_fifo
    #(
        .WIDTH (PIC_FIFO_WIDTH),
        .DEPTH (PIC_FIFO_DEPTH)
    )
    u_fifo
    (
        .clk       (CLK),
        .reset_n   (RESET_N),
        .in_valid  (carry_q),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (CARRY_READY),
        .out_data  (fifo_data_out)
    );

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            carry_valid_q <= 1'b0;
            carry_data_q  <= 8'h00;
        end
        else
        begin
            carry_valid_q <= fifo_valid;
            carry_data_q  <= fifo_data_out;
        end
    end

    assign CARRY_VALID = carry_valid_q;
    assign CARRY_DATA  = carry_data_q;
endmodule

/* File: bench/pic_counter_props.sv */
// Checker: port-level properties of the interval counter
`timescale 1ns/1ns
module pic_counter_props
    import pic_pkg::*;
(
    input wire logic       CLK,
    input wire logic       RESET_N,
    input wire logic [7:0] ADDR,
    input wire logic       WR_EN,
    input wire logic       RD_EN,
    input wire logic [7:0] WR_DATA,
    input wire logic [7:0] RD_DATA,
    input wire logic       TRANSMIT_PIN_DIRECTION,
    input wire logic       TRANSMIT_PIN_OUT,
    input wire logic       TRANSMIT_PIN_OE_N,
    input wire logic       IRQ_ACK,
    input wire logic       SHARED_PIN_IRQ_FLAG,
    input wire logic       CARRY_VALID,
    input wire logic [7:0] CARRY_DATA
);
    logic [7:0] reload_q;
    logic [7:0] reload_d;

    default clocking @(posedge CLK); endclocking

    // Shadow of the last preload write
    always_comb reload_d = (WR_EN && ADDR == PIC_ADDR_RELOAD) ? WR_DATA : reload_q;
    always_ff @(posedge CLK) reload_q <= reload_d;

    ////////////////////////////////////////
    // Reset releases the pin and drops the flag
    reset_state_a: assert property (!RESET_N |=> TRANSMIT_PIN_OUT && TRANSMIT_PIN_OE_N
        && !SHARED_PIN_IRQ_FLAG && RD_DATA == 8'h00) else $error("reset state wrong");
    reload_back_a: assert property (disable iff (!RESET_N)
        WR_EN && ADDR == PIC_ADDR_RELOAD ##1 RD_EN && !WR_EN && ADDR == PIC_ADDR_RELOAD
        |=> RD_DATA == $past(WR_DATA, 2)) else $error("reload read-back wrong");
    count_load_a: assert property (disable iff (!RESET_N)
        WR_EN && ADDR == PIC_ADDR_COUNT ##1 RD_EN && !WR_EN && ADDR == PIC_ADDR_COUNT
        |=> RD_DATA == reload_q) else $error("count write did not load reload");
    ctrl_back_a: assert property (disable iff (!RESET_N)
        WR_EN && ADDR == PIC_ADDR_CTRL ##1 RD_EN && !WR_EN && ADDR == PIC_ADDR_CTRL
        |=> RD_DATA[7:1] == $past(WR_DATA[7:1], 2)) else $error("control read-back wrong");
    // Drive bit forces the buffer on whatever the direction
    oe_forced_a: assert property (disable iff (!RESET_N)
        WR_EN && ADDR == PIC_ADDR_CTRL && WR_DATA[PIC_BIT_TX_DRIVE]
        |-> ##[1:2] !TRANSMIT_PIN_OE_N) else $error("transmit buffer not driven");
    oe_released_a: assert property (disable iff (!RESET_N)
        WR_EN && ADDR == PIC_ADDR_CTRL && !WR_DATA[PIC_BIT_TX_DRIVE]
        ##1 (!WR_EN && !TRANSMIT_PIN_DIRECTION) [*2]
        |=> TRANSMIT_PIN_OE_N) else $error("transmit buffer not released");
    // Flag holds until serviced; output lags the service by a cycle
    flag_sticky_a: assert property (disable iff (!RESET_N)
        SHARED_PIN_IRQ_FLAG && !IRQ_ACK && !$past(IRQ_ACK)
        |=> SHARED_PIN_IRQ_FLAG) else $error("flag dropped without service");
    carry_word_a: assert property (disable iff (!RESET_N)
        CARRY_VALID |-> CARRY_DATA[6:0] == reload_q[6:0]) else $error("carry word wrong");
endmodule

bind pic_counter pic_counter_props i_props (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR),
    .WR_EN(WR_EN), .RD_EN(RD_EN), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA),
    .TRANSMIT_PIN_DIRECTION(TRANSMIT_PIN_DIRECTION), .TRANSMIT_PIN_OUT(TRANSMIT_PIN_OUT),
    .TRANSMIT_PIN_OE_N(TRANSMIT_PIN_OE_N), .IRQ_ACK(IRQ_ACK),
    .SHARED_PIN_IRQ_FLAG(SHARED_PIN_IRQ_FLAG), .CARRY_VALID(CARRY_VALID),
    .CARRY_DATA(CARRY_DATA));

/* File: bench/pic_line_peer.sv */
// Serial line peer: drives the receive pin, watches the transmit wire
`timescale 1ns/1ns
module pic_line_peer
(
    input  wire logic level,
    input  wire logic tx_out,
    input  wire logic tx_oe_n,
    output logic      rx_pin,
    output logic      line
);
    // Peer always drives its own line
    assign rx_pin = level;
    // Pull-up holds the wire high while the device lets go
    assign line = tx_oe_n ? 1'b1 : tx_out;
endmodule

/* File: bench/tb.sv */
// Testbench for the interval counter
`timescale 1ns/1ns
module tb
    import pic_pkg::*;
;
    logic       clk, rst_n, wr_en, rd_en, aux_clk, level, edge_sel, tx_dir;
    logic       irq_ack, c_ready, rx_pin, tx_out, tx_oe_n, irq_flag, c_valid, line;
    logic [7:0] addr, wr_data, rd_data, c_data, v;
    logic [7:0] src [3] = '{8'h48, 8'h08, 8'hC8};
    logic [7:0] exp [3] = '{8'h82, 8'h82, 8'h83};
    int         num_errors, check_count, cycles, n;

    pic_counter i_dut (.CLK(clk), .RESET_N(rst_n), .ADDR(addr), .WR_EN(wr_en),
        .RD_EN(rd_en), .WR_DATA(wr_data), .RD_DATA(rd_data), .AUX_CLK(aux_clk),
        .RECEIVE_PIN(rx_pin), .RECEIVE_PIN_EDGE_SELECT(edge_sel),
        .TRANSMIT_PIN_DIRECTION(tx_dir), .TRANSMIT_PIN_OUT(tx_out),
        .TRANSMIT_PIN_OE_N(tx_oe_n), .IRQ_ACK(irq_ack), .SHARED_PIN_IRQ_FLAG(irq_flag),
        .CARRY_VALID(c_valid), .CARRY_READY(c_ready), .CARRY_DATA(c_data));
    pic_line_peer i_peer (.level(level), .tx_out(tx_out), .tx_oe_n(tx_oe_n),
        .rx_pin(rx_pin), .line(line));

    ////////////////////////////////////////
    task automatic conclude();
        if (num_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    // Strobes stay up into the next call, which re-assigns both of them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_en = 1'b1;
        rd_en = 1'b0;
        addr = a;
        wr_data = d;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        rd_en = 1'b1;
        wr_en = 1'b0;
        addr = a;
        @(negedge clk);
        d = rd_data;
    endtask
    task automatic idle(input int k);
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (k) @(negedge clk);
    endtask

    ////////////////////////////////////////
    // Free-running main clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Hang guard, well above the expected run length
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            conclude();
        end
    end

    // Main sequence
    initial
    begin
        {rst_n, wr_en, rd_en, aux_clk, edge_sel, tx_dir, irq_ack, c_ready} = 8'h00;
        {addr, wr_data} = 16'h0000;
        level = 1'b1;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        idle(1);
        rd(PIC_ADDR_CTRL, v);
        chk("ctrl_reset", 8'h01, v);
        chk("pins_reset", 8'h03, {6'h00, tx_out, tx_oe_n});
        wr(PIC_ADDR_RELOAD, 8'hFC);
        rd(PIC_ADDR_RELOAD, v);
        chk("reload", 8'hFC, v);
        wr(PIC_ADDR_COUNT, 8'h55);
        rd(PIC_ADDR_COUNT, v);
        chk("count_load", 8'hFC, v);
        rd(8'h45, v);
        chk("unmapped", 8'h00, v);
        // Main clock carries every four ticks; stream stalled so the buffer fills
        level = 1'b0;
        wr(PIC_ADDR_CTRL, 8'hB8);
        idle(1);
        chk("tx_before", 8'h02, {6'h00, tx_out, tx_oe_n});
        for (n = 0; n < 40 && c_valid !== 1'b1; n++) @(negedge clk);
        idle(2);
        chk("carry", 8'h05, {5'h00, c_valid, tx_out, irq_flag});
        chk("word", 8'h7C, c_data);
        idle(60);
        wr(PIC_ADDR_CTRL, 8'hB0);
        rd(PIC_ADDR_CTRL, v);
        chk("ctrl_rx", 8'hB0, v);
        idle(2);
        n = 0;
        for (int i = 0; i < 40; i++)
        begin
            if (c_valid === 1'b1)
            begin
                chk("drain", 8'h7C, c_data);
                c_ready = 1'b1;
                @(negedge clk);
                c_ready = 1'b0;
                n++;
            end
            @(negedge clk);
        end
        chk("depth", 8'(PIC_FIFO_DEPTH), 8'(n));
        // Release buffer, direction decides; then service and pin-sourced flag
        wr(PIC_ADDR_CTRL, 8'h00);
        idle(3);
        chk("oe_dir0", 8'h03, {6'h00, line, tx_oe_n});
        tx_dir = 1'b1;
        idle(3);
        chk("oe_dir1", 8'h00, {6'h00, line, tx_oe_n});
        tx_dir = 1'b0;
        irq_ack = 1'b1;
        @(negedge clk);
        irq_ack = 1'b0;
        idle(3);
        chk("flag_ack", 8'h00, {7'h00, irq_flag});
        level = 1'b1;
        idle(8);
        chk("flag_pin", 8'h01, {7'h00, irq_flag});
        // Armed falling start edge begins counting; disarm stops it
        edge_sel = 1'b1;
        wr(PIC_ADDR_RELOAD, 8'h80);
        wr(PIC_ADDR_COUNT, 8'h00);
        wr(PIC_ADDR_CTRL, 8'h84);
        idle(10);
        rd(PIC_ADDR_COUNT, v);
        chk("armed_wait", 8'h80, v);
        level = 1'b0;
        idle(10);
        rd(PIC_ADDR_COUNT, v);
        chk("started", 8'h85, v);
        wr(PIC_ADDR_CTRL, 8'h80);
        wr(PIC_ADDR_COUNT, 8'h00);
        idle(10);
        rd(PIC_ADDR_COUNT, v);
        chk("disarmed", 8'h80, v);
        // Auxiliary, pin and pin-and-main sources
        edge_sel = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            wr(PIC_ADDR_CTRL, src[i]);
            wr(PIC_ADDR_COUNT, 8'h00);
            idle(8);
            if (i < 2)
                repeat (2)
                begin
                    aux_clk = (i == 0);
                    level = (i == 1);
                    idle(6);
                    aux_clk = 1'b0;
                    level = 1'b0;
                    idle(6);
                end
            else
            begin
                level = 1'b1;
                idle(3);
                level = 1'b0;
            end
            idle(8);
            wr(PIC_ADDR_CTRL, 8'h00);
            rd(PIC_ADDR_COUNT, v);
            chk("src_count", exp[i], v);
        end
        idle(2);
        conclude();
    end
endmodule
